// [psw_flash_model.sv]
// Flash array stand-in: answers each request with one done pulse.
// Assumes request pulses are one cycle long and never overlap.
`timescale 1ns/1ps
`default_nettype none
module psw_flash_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic flashProg,
    input wire logic flashErase,
    input wire logic slowMode,
    output logic flashDone
);
    logic [7:0] cnt_r;
    // Countdown from request to the single done pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            flashDone <= 1'b0;
        end else begin
            flashDone <= (cnt_r == 8'h01);
            if (flashProg || flashErase) begin
                cnt_r <= slowMode ? 8'h28 : 8'h03;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule // psw_flash_model
`default_nettype wire

// [psw_key_if.sv]
// Interface carrying key-lock status between the top and lock module.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
`default_nettype none
interface psw_key_if;
    logic keyWrite;
    logic [7:0] keyData;
    logic opDone;
    logic badAttempt;
    logic unlocked;
    logic [1:0] lockState;
    modport ctrl (output keyWrite, output keyData, output opDone,
        output badAttempt, input unlocked, input lockState);
    modport lock (input keyWrite, input keyData, input opDone,
        input badAttempt, output unlocked, output lockState);
endinterface
`default_nettype wire

// [psw_key_lock.sv]
// Key sequence lock for flash write and erase.
// Assumes key writes, done and bad-attempt pulses are one cycle long.
`timescale 1ns/1ps
`default_nettype none
module psw_key_lock
    import psw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    psw_key_if.lock kif
);
    logic [1:0] lock_r;

    // --------------------------------------------------------------
    // Lock state
    // --------------------------------------------------------------
    // Key codes open the lock, one operation closes it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_r <= LOCK_LOCKED;
        end else if (clkEn) begin
            if (lock_r == LOCK_DEAD) begin
                lock_r <= LOCK_DEAD;
            end else if (kif.badAttempt) begin
                lock_r <= LOCK_DEAD;
            end else if (kif.opDone) begin
                lock_r <= LOCK_LOCKED; // R17
            end else if (kif.keyWrite) begin
                case (lock_r)
                    LOCK_LOCKED: begin
                        lock_r <= (kif.keyData == KEY_FIRST) ?
                            LOCK_HALF : LOCK_DEAD; // R16
                    end
                    LOCK_HALF: begin
                        lock_r <= (kif.keyData == KEY_SECOND) ?
                            LOCK_OPEN : LOCK_DEAD; // R16
                    end
                    default: begin
                        lock_r <= LOCK_DEAD;
                    end
                endcase
            end
        end
    end

    assign kif.unlocked = (lock_r == LOCK_OPEN);
    assign kif.lockState = lock_r;
endmodule // psw_key_lock
`default_nettype wire

// [psw_pkg.sv]
// Package for the program store write/erase control block.
// Assumes an 8-bit special-function-register bus from the CPU core.
package psw_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] PSCTRL_ADDR = 8'h8f;
    localparam logic [7:0] KEY_ADDR = 8'hb7;
    localparam logic [7:0] PSCTRL_RESET = 8'h00;
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam int WE_BIT = 0;
    localparam int EE_BIT = 1;
    // --------------------------------------------------------------
    // Key codes and timing
    // --------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'ha5;
    localparam logic [7:0] KEY_SECOND = 8'hf1;
    localparam logic [1:0] LOCK_LOCKED = 2'h0;
    localparam logic [1:0] LOCK_HALF = 2'h1;
    localparam logic [1:0] LOCK_OPEN = 2'h2;
    localparam logic [1:0] LOCK_DEAD = 2'h3;
    localparam int CAL_NS = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CAL_CYCLES = (CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 9;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11
    } psw_op_t;
endpackage

// [psw_store_ctrl.sv]
// Program store write/erase control: steers external move writes to flash.
// Assumes SFR writes/reads are single-cycle strobes on core_clk and
// the flash array answers each request with a one-cycle done pulse.
//
// Functional notes
// R01: With write enable set, a move write programs one flash byte.
// R02: Write enable clear keeps move writes in data RAM.
// R03: Both enables set: move write erases the addressed page.
// R04: Erase enable clear: never erase.
// R05: Control bits 7:2 read zero, writes ignored.
// R06: Interrupts are held while a flash operation runs.
// R07: Regulator calibration runs after every reset.
// R08: Non-power-on reset with high monitor and low regulator holds reset.
// R09: Power-on reset returns monitor to low threshold.
// R10: Firmware sets high monitor threshold while programming flash.
// R11: Firmware enables monitor reset after setting write enable.
// R12: Firmware disables interrupts while write enable is set.
// R13: Firmware writes reset source register whole, power-on flag one.
// R14: Firmware uses internal oscillator during flash operations.
// R15: Firmware erases before programming.
// R16: Flash operation needs key 0xa5 then 0xf1.
// R17: Each completed operation relocks the flash.
// R18: Move reads always access data RAM.
// R19: Both enables clear on any reset.
`timescale 1ns/1ps
`default_nettype none
module psw_store_ctrl
    import psw_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int PW = PAGE_W
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic porEvent,
    input wire logic monHighThreshold,
    input wire logic regBelowHigh,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic movWrite,
    input wire logic movRead,
    input wire logic [AW-1:0] movAddr,
    input wire logic [7:0] movWdata,
    output logic ramWrite,
    output logic ramRead,
    output logic [AW-1:0] ramAddr,
    output logic [7:0] ramWdata,
    output logic flashProg,
    output logic flashErase,
    output logic [AW-1:0] flashAddr,
    output logic [7:0] flashWdata,
    input wire logic flashDone,
    output logic flashBusy,
    output logic irqHold,
    output logic regCalStart,
    output logic holdReset,
    output logic monLowForce
);
    import psw_pkg::*;

    logic weBit_r;
    logic eeBit_r;
    psw_op_t op_r;
    logic [7:0] rdata_r;
    logic calPend_r;
    logic stuck_r;
    logic monLow_r;

    psw_key_if kif ();

    psw_key_lock uLock (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .kif(kif)
    );

    // Page base of an address
    function automatic logic [AW-1:0] pageBase(input logic [AW-1:0] a);
        pageBase = {a[AW-1:PW], {PW{1'b0}}};
    endfunction

    // --------------------------------------------------------------
    // Control register
    // --------------------------------------------------------------
    // Only two enable bits are stored
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            weBit_r <= PSCTRL_RESET[WE_BIT]; // R19
            eeBit_r <= PSCTRL_RESET[EE_BIT]; // R19
        end else if (clkEn && sfrWrite && sfrAddr == PSCTRL_ADDR) begin
            weBit_r <= sfrWdata[WE_BIT];
            eeBit_r <= sfrWdata[EE_BIT]; // R05
        end
    end

    assign kif.keyWrite = clkEn && sfrWrite && sfrAddr == KEY_ADDR;
    assign kif.keyData = sfrWdata;
    assign kif.opDone = clkEn && op_r == ST_BUSY && flashDone;
    assign kif.badAttempt = clkEn && movWrite && weBit_r
        && op_r == ST_IDLE && !kif.unlocked;

    // --------------------------------------------------------------
    // Register read data
    // --------------------------------------------------------------
    // Upper control bits read as zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (clkEn && sfrRead) begin
            case (sfrAddr)
                PSCTRL_ADDR: rdata_r <= {6'h00, eeBit_r, weBit_r}; // R05
                KEY_ADDR: rdata_r <= {6'h00, kif.lockState};
                default: rdata_r <= 8'h00;
            endcase
        end
    end
    assign sfrRdata = rdata_r;

    // --------------------------------------------------------------
    // Move steering
    // --------------------------------------------------------------
    // Writes go to flash while enabled, unlocked and idle; reads always to RAM
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ramWrite <= 1'b0;
            ramRead <= 1'b0;
            ramAddr <= '0;
            ramWdata <= 8'h00;
            flashProg <= 1'b0;
            flashErase <= 1'b0;
            flashAddr <= '0;
            flashWdata <= 8'h00;
        end else if (clkEn) begin
            ramWrite <= movWrite && !weBit_r; // R02
            ramRead <= movRead; // R18
            flashProg <= 1'b0;
            flashErase <= 1'b0;
            if (movRead || (movWrite && !weBit_r)) begin
                ramAddr <= movAddr;
                ramWdata <= movWdata;
            end
            if (movWrite && weBit_r && kif.unlocked && op_r == ST_IDLE) begin
                if (eeBit_r) begin
                    flashErase <= 1'b1; // R03
                    flashAddr <= pageBase(movAddr); // R03
                end else begin
                    flashProg <= 1'b1; // R01 R04
                    flashAddr <= movAddr; // R01
                    flashWdata <= movWdata; // R01
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Operation tracking
    // --------------------------------------------------------------
    // Busy from request until the cycle after the array reports done
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_r <= ST_IDLE;
        end else if (clkEn) begin
            case (op_r)
                ST_IDLE: begin
                    if (movWrite && weBit_r && kif.unlocked) begin
                        op_r <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (flashDone) begin
                        op_r <= ST_DONE;
                    end
                end
                ST_DONE: op_r <= ST_IDLE;
                default: op_r <= ST_IDLE;
            endcase
        end
    end
    assign flashBusy = (op_r != ST_IDLE);
    assign irqHold = (op_r != ST_IDLE); // R06

    // --------------------------------------------------------------
    // Reset supervision
    // --------------------------------------------------------------
    // One calibration pulse after each reset release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            calPend_r <= 1'b1;
        end else if (clkEn) begin
            calPend_r <= 1'b0;
        end
    end
    assign regCalStart = calPend_r; // R07

    // Latch the stuck condition at reset release; porEvent or any reset clears it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stuck_r <= 1'b0;
            monLow_r <= 1'b1;
        end else if (clkEn) begin
            if (porEvent) begin
                stuck_r <= 1'b0; // R09
                monLow_r <= 1'b1; // R09
            end else begin
                monLow_r <= 1'b0;
                if (calPend_r && monHighThreshold && regBelowHigh) begin
                    stuck_r <= 1'b1; // R08
                end
            end
        end
    end
    assign holdReset = stuck_r; // R08
    assign monLowForce = monLow_r | porEvent; // R09
endmodule // psw_store_ctrl
`default_nettype wire

// [psw_store_ctrl_props.sv]
// Checker for the program store control block, bound to its ports.
// Assumes clkEn stays high while the checked relations are exercised.
`timescale 1ns/1ps
`default_nettype none
module psw_store_ctrl_props
    import psw_pkg::*;
#(
    parameter int AW = 16,
    parameter int PW = 9
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic porEvent,
    input wire logic monHighThreshold,
    input wire logic regBelowHigh,
    input wire logic sfrRead,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrRdata,
    input wire logic movRead,
    input wire logic [AW-1:0] movAddr,
    input wire logic ramRead,
    input wire logic [AW-1:0] ramAddr,
    input wire logic flashProg,
    input wire logic flashErase,
    input wire logic [AW-1:0] flashAddr,
    input wire logic flashDone,
    input wire logic flashBusy,
    input wire logic irqHold,
    input wire logic regCalStart,
    input wire logic holdReset,
    input wire logic monLowForce
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Relations between requests and block outputs
    a_upper_zero: assert property (clkEn && sfrRead && sfrAddr == PSCTRL_ADDR
        |=> sfrRdata[7:2] == 6'h00) else $error("control upper bits not zero");
    a_read_to_ram: assert property (clkEn && movRead
        |=> ramRead && ramAddr == $past(movAddr)) else $error("move read lost");
    a_erase_page: assert property (flashErase
        |-> flashAddr[PW-1:0] == '0) else $error("erase address not page base");
    a_single_byte: assert property (flashProg
        |=> !flashProg) else $error("program pulse longer than one cycle");
    a_irq_held: assert property (flashProg || flashErase
        |-> irqHold && flashBusy) else $error("interrupts not held");
    a_busy_ends: assert property (flashDone && flashBusy
        |-> ##2 !flashBusy && !irqHold) else $error("busy did not end");
    a_cal_after_rst: assert property ($past(rst)
        |-> regCalStart) else $error("no calibration after reset");
    a_hold_set: assert property ($past(rst) && !porEvent &&
        monHighThreshold && regBelowHigh |-> ##[0:2] holdReset)
        else $error("reset not held");
    a_por_low: assert property (disable iff (1'b0) rst
        |-> monLowForce) else $error("monitor not forced low");
endmodule // psw_store_ctrl_props
bind psw_store_ctrl psw_store_ctrl_props #(.AW(AW), .PW(PW)) u_props (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .porEvent(porEvent),
    .monHighThreshold(monHighThreshold), .regBelowHigh(regBelowHigh),
    .sfrRead(sfrRead), .sfrAddr(sfrAddr), .sfrRdata(sfrRdata),
    .movRead(movRead), .movAddr(movAddr), .ramRead(ramRead),
    .ramAddr(ramAddr), .flashProg(flashProg), .flashErase(flashErase),
    .flashAddr(flashAddr), .flashDone(flashDone), .flashBusy(flashBusy),
    .irqHold(irqHold), .regCalStart(regCalStart), .holdReset(holdReset),
    .monLowForce(monLowForce));
`default_nettype wire

// [psw_store_ctrl_tb.sv]
// Self-checking bench for the program store control block.
// Assumes the flash model ends every request with one done pulse.
`timescale 1ns/1ps
`default_nettype none
module psw_store_ctrl_tb;
    import psw_pkg::*;
    logic core_clk = 0, rst = 1, clkEn = 1, porEvent = 1, slowMode = 0;
    logic monHighThreshold = 0, regBelowHigh = 0, p = 0, hr = 0;
    logic sfrWrite = 0, sfrRead = 0, movWrite = 0, movRead = 0;
    logic [7:0] sfrAddr = 0, sfrWdata = 0, movWdata = 0, d;
    logic [7:0] sfrRdata, ramWdata, flashWdata;
    logic [15:0] movAddr = 0, ramAddr, flashAddr, a;
    logic ramWrite, ramRead, flashProg, flashErase, flashDone, flashBusy;
    logic irqHold, regCalStart, holdReset, monLowForce;
    logic [26:0] expQ[$];
    int failures = 0, checks_done = 0, seed = 47, i;
    // One internal clock kept through every flash operation
    always #2.5 core_clk = ~core_clk;
    psw_store_ctrl uut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .porEvent(porEvent), .monHighThreshold(monHighThreshold),
        .regBelowHigh(regBelowHigh), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
        .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .movWrite(movWrite), .movRead(movRead), .movAddr(movAddr),
        .movWdata(movWdata), .ramWrite(ramWrite), .ramRead(ramRead),
        .ramAddr(ramAddr), .ramWdata(ramWdata), .flashProg(flashProg),
        .flashErase(flashErase), .flashAddr(flashAddr),
        .flashWdata(flashWdata), .flashDone(flashDone),
        .flashBusy(flashBusy), .irqHold(irqHold), .regCalStart(regCalStart),
        .holdReset(holdReset), .monLowForce(monLowForce));
    psw_flash_model u_flash (.core_clk(core_clk), .rst(rst),
        .flashProg(flashProg), .flashErase(flashErase),
        .slowMode(slowMode), .flashDone(flashDone));
    task cmp(input string what, input logic [26:0] e, input logic [26:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task tick;
        @(posedge core_clk);
        #1;
    endtask
    task sfr(input logic wr, input logic [7:0] ad, input logic [7:0] dt);
        tick;
        {sfrWrite, sfrRead, sfrAddr, sfrWdata} = {wr, !wr, ad, dt};
        if (!wr) expQ.push_back({3'd4, 16'h0000, dt});
        tick;
        {sfrWrite, sfrRead} = 2'b00;
    endtask
    task mov(input logic wr, input logic [15:0] ad, input logic [7:0] dt);
        tick;
        {movWrite, movRead, movAddr, movWdata} = {wr, !wr, ad, dt};
        tick;
        {movWrite, movRead} = 2'b00;
    endtask
    task wait_idle;
        tick;
        for (i = 0; i < 200 && (flashBusy !== 1'b0 || expQ.size()); i++) tick;
        if (i == 200) begin
            failures++;
            end_of_test;
        end
    endtask
    task do_rst(input logic por);
        {rst, porEvent} = {1'b1, por};
        repeat (12) @(posedge core_clk);
        #1 rst = 0;
    endtask
    task check(input logic [26:0] g);
        if (expQ.size() == 0) cmp("unexpected", {3'd7, 24'h0}, g);
        else cmp("result", expQ.pop_front(), g);
    endtask
    // Output watcher: every result takes the oldest note
    always begin
        @(posedge core_clk);
        p = sfrRead;
        #3;
        if (ramWrite === 1'b1) check({3'd0, ramAddr, ramWdata});
        if (ramRead === 1'b1) check({3'd3, ramAddr, 8'h00});
        if (flashProg === 1'b1) check({3'd1, flashAddr, flashWdata});
        if (flashErase === 1'b1) check({3'd2, flashAddr, 8'h00});
        if (p) check({3'd4, 16'h0000, sfrRdata});
        if (holdReset !== hr) check({3'd5, 23'h000000, holdReset});
        hr = holdReset;
    end
    // Main sequence
    initial begin
        do_rst(1);
        sfr(0, PSCTRL_ADDR, PSCTRL_RESET);
        sfr(0, KEY_ADDR, KEY_RESET);
        a = 16'($random(seed));
        d = 8'($random(seed));
        expQ.push_back({3'd0, a, d});
        mov(1, a, d);
        expQ.push_back({3'd3, a, 8'h00});
        mov(0, a, d);
        $display("ram path test done");
        // Frozen clock enable: a move read must leave no result
        tick;
        clkEn = 0;
        mov(0, a, d);
        clkEn = 1;
        $display("clock enable test done");
        sfr(1, PSCTRL_ADDR, 8'hff);
        monHighThreshold = 1;
        sfr(0, PSCTRL_ADDR, 8'h03);
        slowMode = 1;
        sfr(1, KEY_ADDR, KEY_FIRST);
        sfr(1, KEY_ADDR, KEY_SECOND);
        a = 16'($random(seed));
        expQ.push_back({3'd2, a[15:9], 9'h000, 8'h00});
        mov(1, a, 8'h5a);
        expQ.push_back({3'd3, a, 8'h00});
        mov(0, a, d);
        wait_idle;
        $display("erase test done");
        sfr(1, PSCTRL_ADDR, 8'h01);
        sfr(1, KEY_ADDR, KEY_FIRST);
        sfr(1, KEY_ADDR, KEY_SECOND);
        slowMode = 0;
        a = 16'($random(seed));
        d = 8'($random(seed));
        expQ.push_back({3'd1, a, d});
        mov(1, a, d);
        wait_idle;
        mov(1, a + 16'h0001, d);
        sfr(0, KEY_ADDR, {6'h00, LOCK_DEAD});
        sfr(1, PSCTRL_ADDR, 8'h02);
        monHighThreshold = 0;
        expQ.push_back({3'd0, a, d});
        mov(1, a, d);
        wait_idle;
        $display("program and relock test done");
        {monHighThreshold, regBelowHigh} = 2'b11;
        expQ.push_back({3'd5, 23'h000000, 1'b1});
        do_rst(0);
        repeat (3) tick;
        expQ.push_back({3'd5, 23'h000000, 1'b0});
        porEvent = 1;
        repeat (3) tick;
        sfr(0, PSCTRL_ADDR, PSCTRL_RESET);
        wait_idle;
        $display("reset hold test done");
        end_of_test;
    end
endmodule // psw_store_ctrl_tb
`default_nettype wire
